// ### pccr_pkg.sv
// package: command codes, field layout, reset values and carrier types
package pccr_pkg;
  // command sub-addresses
  localparam logic [7:0] CMD_VSYNC_HINT = 8'h0A;
  localparam logic [7:0] CMD_INDEX_CLK  = 8'h0B;
  localparam logic [7:0] CMD_HW_PROBE   = 8'h0C;
  localparam logic [7:0] CMD_FW_PROBE   = 8'h0D;
  localparam logic [7:0] CMD_DBG_MASK   = 8'h0E;
  localparam logic [7:0] CMD_USB_DBG    = 8'h0F;
  localparam logic [7:0] CMD_FLIP       = 8'h10;
  localparam logic [7:0] CMD_PATTERN    = 8'h11;
  localparam logic [7:0] CMD_TIMING     = 8'h12;
  localparam logic [7:0] CMD_RD_SELECT  = 8'h15;
  // field positions
  localparam int ROLE_BIT    = 15;
  localparam int POINT_LO    = 8;
  localparam int USB_EN_BIT  = 16;
  localparam int VFLIP_BIT   = 1;
  localparam int HFLIP_BIT   = 0;
  localparam int READY_BIT   = 0;
  localparam logic [4:0] HW_CODE_MAX = 5'h0C;
  localparam logic [4:0] FW_CODE_MAX = 5'h07;
  localparam logic [3:0] PATTERN_LIMIT = 4'hA;
  // writable debug categories; everything else is reserved
  localparam logic [47:0] DBG_WR_MASK = 48'h0010_F0EF_FFFF;
  localparam logic [15:0] PROBE_WR_MASK = 16'h871F;
  // values after reset
  localparam logic [15:0] HINT_RST    = 16'h0000;
  localparam logic [47:0] MASK_RST    = 48'h0000_0000_0000;
  localparam logic [23:0] TIMING_RST  = 24'h00_0000;
  localparam logic [3:0]  PATTERN_RST = 4'h0;
  // cycles the ready output stays low after a command is taken
  localparam int EXEC_CYCLES = 4;
  localparam int SEQ_CLK_HZ_DEF = 100_000_000;

  typedef struct packed {
    logic       secondary;
    logic [2:0] point;
    logic [4:0] code;
  } pccr_probe_sel_t;

  typedef struct packed {
    logic [7:0] clock_rate;
    logic [7:0] vertical_blank;
    logic [7:0] frame_rate;
  } pccr_tpg_timing_t;

  typedef struct packed {
    logic        en;
    logic [15:0] buf_size;
  } pccr_usb_dbg_t;

  // data bytes a write needs; zero means not writable
  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    unique case (c)
      CMD_VSYNC_HINT, CMD_HW_PROBE, CMD_FW_PROBE: cmd_len = 3'd2;
      CMD_DBG_MASK:                               cmd_len = 3'd6;
      CMD_USB_DBG, CMD_TIMING:                    cmd_len = 3'd3;
      CMD_FLIP, CMD_PATTERN, CMD_RD_SELECT:       cmd_len = 3'd1;
      default:                                    cmd_len = 3'd0;
    endcase
  endfunction

  // pack a probe command into its table entry
  function automatic pccr_probe_sel_t probe_sel(input logic [15:0] v);
    probe_sel = '{secondary: v[ROLE_BIT], point: v[10:8], code: v[4:0]};
  endfunction
endpackage

// ### pccr_cmd_regs.sv
// command registers 0x0A..0x12 of the projector controller
// Notes on behaviour
// - 16-bit read/write vsync frequency hint for the wheel lock, reset zero
// - read-only period is difference of two successive index captures
// - read-only frequency is sequence clock rate divided by the period
// - newest hardware probe command for a point replaces earlier ones
// - bit 15 picks primary (0) or secondary (1) controller
// - bits 10..8 pick one of eight probe points
// - hardware codes 0..12 route wheel, sequence and aux signals
// - firmware codes 0..7 route firmware activity markers
// - all ones enables every debug category, zeros disable; reset zero
// - each listed debug mask bit enables one message category
// - low two bytes hold string size allocated and used
// - usb debug: bit 16 enable, bits 15..0 buffer size, write only
// - orientation bit 1 mirrors vertically, reset off
// - orientation bit 0 mirrors horizontally, reset off
// - pattern 0..9 loads pattern, shows test pattern, stops autolock
// - pattern ten or above disables the pattern generator
// - timing holds clock rate, vertical blank, frame rate, reset zero
// - ready output held low while a taken command executes
// - reads return two status bytes then the selected register
module pccr_cmd_regs
  import pccr_pkg::*;
#(
  parameter int SEQ_CLK_HZ = pccr_pkg::SEQ_CLK_HZ_DEF
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rstn_in,
  input  wire logic                       cmd_start_in,
  input  wire logic                       cmd_byte_valid_in,
  input  wire logic [7:0]                 cmd_byte_in,
  input  wire logic                       cmd_stop_in,
  input  wire logic                       rd_start_in,
  input  wire logic                       rd_next_in,
  output logic [7:0]                      rd_byte_out,
  output logic                            controller_ready_n_out,
  input  wire logic                       unit_is_secondary_in,
  input  wire logic                       wheel_index_in,
  input  wire logic [12:0]                hw_probe_src_in,
  input  wire logic [7:0]                 fw_probe_src_in,
  output logic [7:0]                      hw_probe_out,
  output logic [7:0]                      fw_probe_out,
  output logic [15:0]                     wheel_vsync_hint_out,
  output logic [47:0]                     debug_message_mask_out,
  output pccr_pkg::pccr_usb_dbg_t         usb_debug_out,
  output logic                            vertical_mirror_en_out,
  output logic                            horizontal_mirror_en_out,
  output logic [3:0]                      pattern_number_out,
  output logic                            pattern_load_out,
  output logic                            pattern_disable_out,
  output logic                            autolock_stop_out,
  output logic                            test_pattern_active_out,
  output pccr_pkg::pccr_tpg_timing_t      pattern_timing_out
);
  import pccr_pkg::*;

  // elaboration check: the divider needs a positive clock rate
  if (SEQ_CLK_HZ < 1) begin : g_bad_rate
    $error("sequence clock rate must be positive");
  end

  typedef enum logic {DIV_IDLE, DIV_RUN} pccr_div_st_t;

  logic              open_r, busy, commit;
  logic [7:0]        sub_r, rd_sel_r;
  logic [2:0]        cnt_r;
  logic [47:0]       sh_r;
  logic [3:0]        exec_r;
  pccr_probe_sel_t   hw_tab_r [8];
  pccr_probe_sel_t   fw_tab_r [8];
  logic [15:0]       hw_last_r, fw_last_r;
  logic [1:0]        flip_r;
  logic              idx_d_r, cap_ok_r, idx_edge;
  logic [31:0]       timer_r, cap_r, period_r, freq_r;
  pccr_div_st_t      div_st_r;
  logic [31:0]       dvd_r, quo_r, dvs_r;
  logic [32:0]       rem_r, rem_sh;
  logic [4:0]        step_r;
  logic [3:0]        rd_ptr_r, rd_ptr_nxt;
  logic [63:0]       rdata;
  logic [79:0]       rbuf;

  assign busy = (exec_r != 4'h0);
  assign controller_ready_n_out = !busy; // driven low while a command executes
  // a write is taken only if enough bytes came; extras were dropped
  assign commit = cmd_stop_in && open_r && !busy && cnt_r >= cmd_len(sub_r)
                  && cmd_len(sub_r) != 3'd0;

  // byte collection; bytes arriving while busy are refused
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_r <= 1'b0;
      sub_r  <= 8'h00;
      cnt_r  <= 3'd0;
      sh_r   <= '0;
    end else if (busy || cmd_stop_in) begin
      open_r <= 1'b0;
    end else if (cmd_start_in) begin
      open_r <= 1'b1;
      sub_r  <= 8'h00;
      cnt_r  <= 3'd0;
    end else if (open_r && cmd_byte_valid_in) begin
      if (cnt_r == 3'd0 && sub_r == 8'h00) begin
        sub_r <= cmd_byte_in;
        cnt_r <= 3'd0;
        open_r <= (cmd_byte_in != 8'h00);
      end else if (cnt_r < cmd_len(sub_r)) begin
        sh_r  <= {sh_r[39:0], cmd_byte_in};
        cnt_r <= cnt_r + 3'd1;
      end
    end
  end

  // execution time during which the ready line is low
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)   exec_r <= 4'h0;
    else if (commit) exec_r <= 4'(EXEC_CYCLES);
    else if (busy)  exec_r <= exec_r - 4'h1;
  end

  // plain stored registers; reserved bits never stored
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wheel_vsync_hint_out   <= HINT_RST;
      debug_message_mask_out <= MASK_RST;
      usb_debug_out          <= '0;
      flip_r                 <= 2'b00;
      pattern_timing_out     <= TIMING_RST;
      rd_sel_r               <= 8'h00;
    end else if (commit) begin
      unique case (sub_r)
        CMD_VSYNC_HINT: wheel_vsync_hint_out <= sh_r[15:0];
        // categories and string sizes, reserved cleared
        CMD_DBG_MASK: debug_message_mask_out <= sh_r & DBG_WR_MASK;
        CMD_USB_DBG: usb_debug_out <= '{en: sh_r[USB_EN_BIT],
                                        buf_size: sh_r[15:0]};
        CMD_FLIP: flip_r <= {sh_r[VFLIP_BIT], sh_r[HFLIP_BIT]};
        CMD_TIMING: pattern_timing_out <= sh_r[23:0];
        CMD_RD_SELECT: rd_sel_r <= sh_r[7:0];
        default: ;
      endcase
    end
  end
  assign vertical_mirror_en_out   = flip_r[1];
  assign horizontal_mirror_en_out = flip_r[0];

  // probe tables, one entry per point; last writer for a point wins
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 8; i++) begin
        hw_tab_r[i] <= '0;
        fw_tab_r[i] <= '0;
      end
      hw_last_r <= 16'h0000;
      fw_last_r <= 16'h0000;
    end else if (commit && sub_r == CMD_HW_PROBE) begin
      hw_tab_r[sh_r[10:8]] <= probe_sel(sh_r[15:0]);
      hw_last_r <= sh_r[15:0] & PROBE_WR_MASK;
    end else if (commit && sub_r == CMD_FW_PROBE) begin
      fw_tab_r[sh_r[10:8]] <= probe_sel(sh_r[15:0]);
      fw_last_r <= sh_r[15:0] & PROBE_WR_MASK;
    end
  end

  // routing; a point aimed at the other controller stays low
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hw_probe_out <= 8'h00;
      fw_probe_out <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        hw_probe_out[i] <= (hw_tab_r[i].secondary == unit_is_secondary_in)
                           && hw_tab_r[i].code <= HW_CODE_MAX
                           && hw_probe_src_in[hw_tab_r[i].code[3:0]];
        fw_probe_out[i] <= (fw_tab_r[i].secondary == unit_is_secondary_in)
                           && fw_tab_r[i].code <= FW_CODE_MAX
                           && fw_probe_src_in[fw_tab_r[i].code[2:0]];
      end
    end
  end

  // pattern selection: low numbers load, ten and up disable
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pattern_number_out      <= PATTERN_RST;
      pattern_load_out        <= 1'b0;
      pattern_disable_out     <= 1'b0;
      autolock_stop_out       <= 1'b0;
      test_pattern_active_out <= 1'b0;
    end else begin
      pattern_load_out    <= 1'b0;
      pattern_disable_out <= 1'b0;
      autolock_stop_out   <= 1'b0;
      if (commit && sub_r == CMD_PATTERN) begin
        pattern_number_out <= sh_r[3:0];
        if (sh_r[3:0] < PATTERN_LIMIT) begin
          pattern_load_out        <= 1'b1;
          autolock_stop_out       <= 1'b1;
          test_pattern_active_out <= 1'b1;
        end else begin
          pattern_disable_out     <= 1'b1;
          test_pattern_active_out <= 1'b0;
        end
      end
    end
  end

  // index capture against a free timer; wrap is harmless in the difference
  assign idx_edge = wheel_index_in && !idx_d_r;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idx_d_r  <= 1'b0;
      cap_ok_r <= 1'b0;
      timer_r  <= '0;
      cap_r    <= '0;
      period_r <= '0;
    end else begin
      idx_d_r <= wheel_index_in;
      timer_r <= timer_r + 32'h1;
      if (idx_edge) begin
        cap_r    <= timer_r;
        cap_ok_r <= 1'b1;
        if (cap_ok_r) period_r <= timer_r - cap_r;
      end
    end
  end

  // serial divider, one quotient bit a cycle; a zero period is skipped
  assign rem_sh = {rem_r[31:0], dvd_r[31]};
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_st_r <= DIV_IDLE;
      dvd_r    <= '0;
      dvs_r    <= '0;
      quo_r    <= '0;
      rem_r    <= '0;
      step_r   <= 5'd0;
      freq_r   <= '0;
    end else begin
      unique case (div_st_r)
        DIV_IDLE: begin
          if (idx_edge && cap_ok_r && timer_r != cap_r) begin
            dvd_r    <= 32'(SEQ_CLK_HZ);
            dvs_r    <= timer_r - cap_r;
            rem_r    <= '0;
            step_r   <= 5'd31;
            div_st_r <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          dvd_r <= {dvd_r[30:0], 1'b0};
          if (rem_sh >= {1'b0, dvs_r}) begin
            rem_r <= rem_sh - {1'b0, dvs_r};
            quo_r <= {quo_r[30:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[30:0], 1'b0};
          end
          if (step_r == 5'd0) begin
            freq_r   <= {quo_r[30:0], (rem_sh >= {1'b0, dvs_r})};
            div_st_r <= DIV_IDLE;
          end
          step_r <= step_r - 5'd1;
        end
      endcase
    end
  end

  // read-back data, left aligned; write-only and unknown read as zero
  always_comb begin
    rdata = '0;
    unique case (rd_sel_r)
      CMD_VSYNC_HINT: rdata[63:48] = wheel_vsync_hint_out;
      CMD_INDEX_CLK:  rdata = {period_r, freq_r};
      CMD_HW_PROBE:   rdata[63:48] = hw_last_r;
      CMD_FW_PROBE:   rdata[63:48] = fw_last_r;
      CMD_DBG_MASK:   rdata[63:16] = debug_message_mask_out;
      CMD_FLIP:       rdata[63:56] = {6'h00, flip_r};
      CMD_PATTERN:    rdata[63:56] = {4'h0, pattern_number_out};
      CMD_TIMING:     rdata[63:40] = pattern_timing_out;
      default:        rdata = '0;
    endcase
  end
  assign rbuf = {7'h00, !busy, 8'h00, rdata};
  assign rd_ptr_nxt = rd_start_in ? 4'h0 : rd_ptr_r + 4'h1;

  // two status bytes, then register bytes most significant first
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_ptr_r    <= 4'h0;
      rd_byte_out <= 8'h00;
    end else if (rd_start_in || (rd_next_in && rd_ptr_r < 4'd9)) begin
      rd_ptr_r    <= rd_ptr_nxt;
      rd_byte_out <= rbuf[79 - 8 * rd_ptr_nxt -: 8];
    end
  end

  property p_ready_low;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      commit |=> (!controller_ready_n_out) [*4] ##1 controller_ready_n_out;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready timing wrong");

  property p_hint;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      commit && sub_r == CMD_VSYNC_HINT |=> wheel_vsync_hint_out == $past(sh_r[15:0]);
  endproperty
  a_hint: assert property (p_hint) else $error("hint not stored");

  property p_period;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      idx_edge && cap_ok_r |=> period_r == $past(timer_r) - $past(cap_r);
  endproperty
  a_period: assert property (p_period) else $error("period wrong");

  property p_freq;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      div_st_r == DIV_RUN && step_r == 5'd0 |=> freq_r == 32'(SEQ_CLK_HZ) / dvs_r;
  endproperty
  a_freq: assert property (p_freq) else $error("frequency wrong");

  property p_probe_last;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      commit && sub_r == CMD_HW_PROBE |=> hw_tab_r[$past(sh_r[10:8])].code == $past(sh_r[4:0]);
  endproperty
  a_probe_last: assert property (p_probe_last) else $error("probe not replaced");

  property p_role;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      hw_probe_out[0] |-> $past(hw_tab_r[0].secondary == unit_is_secondary_in);
  endproperty
  a_role: assert property (p_role) else $error("probe on wrong unit");

  property p_mask_rsvd;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (debug_message_mask_out & ~DBG_WR_MASK) == 48'h0;
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("reserved mask bit set");

  property p_flip;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      commit && sub_r == CMD_FLIP |=> vertical_mirror_en_out == $past(sh_r[1])
        && horizontal_mirror_en_out == $past(sh_r[0]);
  endproperty
  a_flip: assert property (p_flip) else $error("flip not stored");

  property p_pat_off;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      commit && sub_r == CMD_PATTERN && sh_r[3:0] >= PATTERN_LIMIT
        |=> pattern_disable_out && !pattern_load_out && !test_pattern_active_out;
  endproperty
  a_pat_off: assert property (p_pat_off) else $error("pattern not disabled");
endmodule // pccr_cmd_regs

// ### pccr_host_model.sv
// host model: drives command writes and read-backs on the serial command port
module pccr_host_model
  import pccr_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       ready_n_in,
  input  wire logic [7:0] rd_byte_in,
  output logic            start_out,
  output logic            valid_out,
  output logic [7:0]      byte_out,
  output logic            stop_out,
  output logic            rd_start_out,
  output logic            rd_next_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial begin
    {start_out, valid_out, stop_out, rd_start_out, rd_next_out} = '0;
    byte_out = 8'h00;
  end

  // bounded wait so a stuck busy line cannot hang the host
  task automatic idle();
    int i;
    for (i = 0; i < 50 && ready_n_in !== 1'b1; i++) @(negedge ref_clk_in);
  endtask

  // sub-address then n data bytes, most significant first; w waits out execution
  task automatic wr(input logic [7:0] c, input logic [47:0] d, input int n, input bit w);
    int i;
    @(negedge ref_clk_in) start_out = 1'b1;
    @(negedge ref_clk_in) start_out = 1'b0;
    valid_out = 1'b1;
    byte_out = c;
    for (i = n - 1; i >= 0; i--) @(negedge ref_clk_in) byte_out = d[8*i +: 8];
    @(negedge ref_clk_in) valid_out = 1'b0;
    byte_out = ~byte_out; // released data does not keep its last value
    stop_out = 1'b1;
    @(negedge ref_clk_in) stop_out = 1'b0;
    if (w) begin
      @(negedge ref_clk_in);
      idle();
    end
  endtask

  // select a register, then read n bytes back to back
  task automatic rd(input logic [7:0] c, input int n, output logic [7:0] q [10]);
    int i;
    wr(CMD_RD_SELECT, {40'h0, c}, 1, 1'b1);
    @(negedge ref_clk_in) rd_start_out = 1'b1;
    for (i = 0; i < n; i++) begin
      @(negedge ref_clk_in) q[i] = rd_byte_in;
      rd_start_out = 1'b0;
      rd_next_out = (i < n - 1);
    end
  endtask
endmodule // pccr_host_model

// ### tb_top.sv
// self-checking bench for the command register block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pccr_pkg::*;

  typedef struct {
    logic [7:0]  c;
    logic [47:0] d;
    int          n;
    logic [47:0] e;
  } pccr_tb_row_t;

  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              sec = 1'b0;
  logic              start, valid, stop, rs, rn, rdy_n, wix = 1'b0;
  logic              vm, hm, pload, pdis, astop, pact;
  logic [7:0]        cbyte, rbyte, hwo, fwo;
  logic [15:0]       hint;
  logic [47:0]       mask;
  logic [3:0]        pnum;
  pccr_usb_dbg_t     usb;
  pccr_tpg_timing_t  ptim;
  logic [7:0]        q [10];
  int                bad_count = 0, compares = 0, cyc = 0, bcnt, lcnt, dcnt, scnt, i;

  // low sequence clock rate keeps the frequency a small exact quotient
  pccr_cmd_regs #(.SEQ_CLK_HZ(1000)) DUT (
    .ref_clk_in(clk), .rstn_in(rstn), .cmd_start_in(start), .cmd_byte_valid_in(valid),
    .cmd_byte_in(cbyte), .cmd_stop_in(stop), .rd_start_in(rs), .rd_next_in(rn),
    .rd_byte_out(rbyte), .controller_ready_n_out(rdy_n), .unit_is_secondary_in(sec),
    .wheel_index_in(wix), .hw_probe_src_in(13'h1004), .fw_probe_src_in(8'hC0),
    .hw_probe_out(hwo), .fw_probe_out(fwo), .wheel_vsync_hint_out(hint),
    .debug_message_mask_out(mask), .usb_debug_out(usb), .vertical_mirror_en_out(vm),
    .horizontal_mirror_en_out(hm), .pattern_number_out(pnum), .pattern_load_out(pload),
    .pattern_disable_out(pdis), .autolock_stop_out(astop), .test_pattern_active_out(pact),
    .pattern_timing_out(ptim));

  pccr_host_model HOST (
    .ref_clk_in(clk), .ready_n_in(rdy_n), .rd_byte_in(rbyte), .start_out(start),
    .valid_out(valid), .byte_out(cbyte), .stop_out(stop), .rd_start_out(rs),
    .rd_next_out(rn));

  always #5 clk = ~clk;

  // busy cycles and one-cycle pulses are counted, not sampled, so no edge is missed
  always @(posedge clk) begin
    cyc++;
    if (rdy_n === 1'b0) bcnt++;
    if (pload === 1'b1) lcnt++;
    if (pdis === 1'b1) dcnt++;
    if (astop === 1'b1) scnt++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  // ordinary writes, each followed by a look at the output it drives
  pccr_tb_row_t rows [15] = '{
    '{CMD_VSYNC_HINT, 48'hBEEF, 2, 48'hBEEF},
    '{CMD_VSYNC_HINT, 48'h55, 1, 48'hBEEF},           // short write dropped
    '{CMD_DBG_MASK, {48{1'b1}}, 6, 48'h0010_F0EF_FFFF},
    '{CMD_DBG_MASK, 48'h0, 6, 48'h0},
    '{CMD_USB_DBG, 48'hFF_ABCD, 3, 48'h1_ABCD},
    '{CMD_FLIP, 48'hFE, 1, 48'h2},
    '{CMD_FLIP, 48'h0103, 2, 48'h1},
    '{CMD_TIMING, 48'h12_3456, 3, 48'h12_3456},
    '{CMD_HW_PROBE, 48'h0302, 2, 48'h08},
    '{CMD_HW_PROBE, 48'h0301, 2, 48'h00},
    '{CMD_HW_PROBE, 48'h070C, 2, 48'h80},
    '{CMD_HW_PROBE, 48'h0002, 2, 48'h81},
    '{CMD_HW_PROBE, 48'h860C, 2, 48'h81},
    '{CMD_FW_PROBE, 48'h0207, 2, 48'h04},
    '{CMD_FW_PROBE, 48'h0506, 2, 48'h24}
  };

  function automatic logic [47:0] obs(input logic [7:0] c);
    case (c)
      CMD_VSYNC_HINT: obs = {32'h0, hint};
      CMD_DBG_MASK:   obs = mask;
      CMD_USB_DBG:    obs = {31'h0, usb};
      CMD_FLIP:       obs = {46'h0, vm, hm};
      CMD_TIMING:     obs = {24'h0, ptim};
      CMD_HW_PROBE:   obs = {40'h0, hwo};
      default:        obs = {40'h0, fwo};
    endcase
  endfunction

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    foreach (rows[k]) begin
      HOST.wr(rows[k].c, rows[k].d, rows[k].n, 1'b1);
      chk(obs(rows[k].c), rows[k].e);
    end
    // as secondary unit only the point aimed at the secondary stays routed
    sec = 1'b1;
    repeat (2) @(negedge clk);
    chk({hwo, fwo}, 16'h4000);
    sec = 1'b0;
    // second write lands while the first executes and must be ignored
    bcnt = 0;
    HOST.wr(CMD_FLIP, 48'h03, 1, 1'b0);
    HOST.wr(CMD_FLIP, 48'h00, 1, 1'b1);
    chk({vm, hm}, 2'b11);
    chk(bcnt, EXEC_CYCLES);
    // last loaded pattern and first disabling value
    lcnt = 0;
    dcnt = 0;
    scnt = 0;
    HOST.wr(CMD_PATTERN, 48'h09, 1, 1'b1);
    chk({lcnt[3:0], scnt[3:0], dcnt[3:0], 3'h0, pact, pnum}, 20'h1101_9);
    HOST.wr(CMD_PATTERN, 48'h0A, 1, 1'b1);
    chk({lcnt[3:0], scnt[3:0], dcnt[3:0], 3'h0, pact, pnum}, 20'h1110_A);
    // read-back of the hint behind two status bytes
    HOST.wr(CMD_VSYNC_HINT, 48'hC3A5, 2, 1'b1);
    HOST.rd(CMD_VSYNC_HINT, 4, q);
    chk({q[0], q[1], q[2], q[3]}, 32'h0100_C3A5);
    // wheel index edges 40 cycles apart
    repeat (6) begin
      wix = ~wix;
      repeat (20) @(negedge clk);
    end
    repeat (40) @(negedge clk);
    HOST.rd(CMD_INDEX_CLK, 10, q);
    chk({q[0], q[1], q[2], q[3], q[4], q[5], q[6], q[7], q[8], q[9]},
        {16'h0100, 32'd40, 32'd25});
    // reset in mid-run clears every register
    @(negedge clk) rstn = 1'b0;
    @(negedge clk);
    chk({hint, mask}, 64'h0);
    chk({usb, ptim, pnum, vm, hm, pact, hwo, fwo, rdy_n}, {64'h0, 1'b1});
    rstn = 1'b1;
    // block must take commands again right after release
    HOST.wr(CMD_VSYNC_HINT, 48'h0102, 2, 1'b1);
    chk(hint, 16'h0102);
    end_sim();
  end
endmodule // tb_top
